// file: src/acc_comparator_control.sv
// Local design decision: the Wishbone slave port.
`timescale 1ns/1ps
// Contract
// - Bit 7 picks pin or temperature sensor
// - Bit 6 enables reference as negative input
// - Bits 5:2 set reference, 0.2 V steps
// - Result raises interrupt and drives pin mux
// - Separate power bit powers comparator down
module acc_comparator_control
  import acc_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [acc_pkg::ACC_ADDR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic wb_err_o,
  // Analog comparator side
  input wire logic cmp_out_i,
  output logic positive_input_select_o,
  output logic negative_input_select_o,
  output logic ref_enable_o,
  output logic [3:0] reference_level_o,
  output logic cmp_power_down_o,
  // Result routing
  output logic cmp_irq_src_o,
  output logic cmp_pin_o,
  output logic irq_o
);
  acc_bus_t state_r;
  acc_bus_t state_nxt;
  logic [7:0] ctrl_r;
  logic [7:0] ctrl_nxt;
  logic [1:0] stat_r;
  logic [1:0] stat_nxt;
  logic [1:0] mask_r;
  logic [1:0] mask_nxt;
  logic pwr_r;
  logic pwr_nxt;
  logic cmp_r;
  logic cmp_nxt;
  logic [31:0] rdat_r;
  logic [31:0] rdat_nxt;
  logic err_r;
  logic err_nxt;
  logic rise;
  logic fall;
  logic req;
  logic wr0;
  logic rd_req;
  logic sel_ctrl;
  logic sel_stat;
  logic sel_mask;
  logic sel_pwr;
  logic sel_none;

  // Which register an address selects
  function automatic logic hit(input logic [ACC_ADDR_W-1:0] a, input logic [ACC_ADDR_W-1:0] r);
    hit = (a == r);
  endfunction : hit

  // Reserved reference codes fall back to the top legal level
  function automatic logic [3:0] clamp_ref(input logic [3:0] c);
    clamp_ref = (c > ACC_REF_MAX) ? ACC_REF_MAX : c;
  endfunction : clamp_ref

  assign req = wb_cyc_i & wb_stb_i & (state_r == ACC_IDLE);
  assign wr0 = req & wb_we_i & wb_sel_i[0];
  assign rd_req = req & ~wb_we_i;

  // Address decode; at most one mapped register matches
  assign sel_ctrl = hit(wb_adr_i, ACC_CTRL_ADDR);
  assign sel_stat = hit(wb_adr_i, ACC_STAT_ADDR);
  assign sel_mask = hit(wb_adr_i, ACC_MASK_ADDR);
  assign sel_pwr = hit(wb_adr_i, ACC_PWR_ADDR);
  assign sel_none = ~(sel_ctrl | sel_stat | sel_mask | sel_pwr);

  // Edges of the registered comparator level
  acc_edge_detect u_edge (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .level_i(cmp_r),
    .enable_i(~pwr_r),
    .rise_o(rise),
    .fall_o(fall)
  );

  // Bus answer; one wait state, ack or err the cycle after the taking edge
  always_comb
  begin
    state_nxt = state_r;
    err_nxt = err_r;
    unique case (state_r)
      ACC_IDLE:
      begin
        err_nxt = 1'h0;
        if (req)
        begin
          state_nxt = ACC_ACK;
          err_nxt = sel_none; // Unmapped address answers with err, writes nothing
        end
      end
      ACC_ACK:
      begin
        // A request still held here is not taken a second time
        state_nxt = ACC_IDLE;
        err_nxt = 1'h0;
      end
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      state_r <= ACC_IDLE;
      err_r <= 1'h0;
    end
    else
    begin
      state_r <= state_nxt;
      err_r <= err_nxt;
    end
  end

  // Configuration registers; only byte lane 0 carries their bits
  always_comb
  begin
    ctrl_nxt = ctrl_r;
    mask_nxt = mask_r;
    pwr_nxt = pwr_r;
    if (wr0 & sel_ctrl)
      ctrl_nxt = {wb_dat_i[7:2], 2'h0};
    if (wr0 & sel_mask)
      mask_nxt = wb_dat_i[1:0];
    if (wr0 & sel_pwr)
      pwr_nxt = wb_dat_i[0];
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ctrl_r <= ACC_CTRL_RST;
      mask_r <= ACC_MASK_RST;
      pwr_r <= ACC_PWR_DOWN_RST;
    end
    else
    begin
      ctrl_r <= ctrl_nxt;
      mask_r <= mask_nxt;
      pwr_r <= pwr_nxt;
    end
  end

  // Read data latched at the taking edge, held until the next access
  always_comb
  begin
    rdat_nxt = rdat_r;
    if (req)
    begin
      rdat_nxt = 32'h0;
      if (sel_ctrl)
        rdat_nxt = {24'h0, ctrl_r};
      else if (sel_stat)
        rdat_nxt = {30'h0, stat_r};
      else if (sel_mask)
        rdat_nxt = {30'h0, mask_r};
      else if (sel_pwr)
        rdat_nxt = {31'h0, pwr_r};
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      rdat_r <= 32'h0;
    else
      rdat_r <= rdat_nxt;
  end

  // Sticky event flags; a new event wins over a clearing read in the same cycle
  always_comb
  begin
    stat_nxt = stat_r;
    if (rd_req & sel_stat)
      stat_nxt = 2'h0; // Read clears status
    if (rise)
      stat_nxt[ACC_ST_RISE] = 1'h1;
    if (fall)
      stat_nxt[ACC_ST_FALL] = 1'h1;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      stat_r <= 2'h0;
    else
      stat_r <= stat_nxt;
  end

  // Comparator level sample; input is already synchronous, one flop suffices
  always_comb
  begin
    cmp_nxt = cmp_out_i;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      cmp_r <= 1'h0;
    else
      cmp_r <= cmp_nxt;
  end

  // Bus outputs
  assign wb_ack_o = (state_r == ACC_ACK) & ~err_r;
  assign wb_err_o = (state_r == ACC_ACK) & err_r;
  assign wb_dat_o = rdat_r;

  // Analog configuration from the control register, power down and reference gating from the power bit
  assign positive_input_select_o = ctrl_r[ACC_POSITIVE_INPUT_SELECT_BIT];
  assign negative_input_select_o = ctrl_r[ACC_NEGATIVE_INPUT_SELECT_BIT];
  assign ref_enable_o = ctrl_r[ACC_NEGATIVE_INPUT_SELECT_BIT] & ~pwr_r;
  assign reference_level_o = clamp_ref(ctrl_r[ACC_REF_MSB:ACC_REF_LSB]);
  assign cmp_power_down_o = pwr_r;

  // Result routing; masked while powered down since the output is meaningless
  assign cmp_irq_src_o = cmp_r & ~pwr_r;
  assign cmp_pin_o = cmp_r & ~pwr_r;
  // Level interrupt; software masks it during reconfiguration
  assign irq_o = |(stat_r & mask_r);
endmodule : acc_comparator_control

// file: include/acc_pkg.sv
package acc_pkg;
  // Register byte offsets (classic Wishbone, one word per register)
  localparam logic [7:0] ACC_CTRL_IDX = 8'hF9; // Register index, scaled to a byte address below
  localparam logic [9:0] ACC_CTRL_ADDR = {ACC_CTRL_IDX, 2'h0};
  localparam logic [9:0] ACC_STAT_ADDR = 10'h3F0;
  localparam logic [9:0] ACC_MASK_ADDR = 10'h3F4;
  localparam logic [9:0] ACC_PWR_ADDR = 10'h3F8;
  localparam int ACC_ADDR_W = 10;
  // Control field positions
  localparam int ACC_POSITIVE_INPUT_SELECT_BIT = 7;
  localparam int ACC_NEGATIVE_INPUT_SELECT_BIT = 6;
  localparam int ACC_REF_MSB = 5;
  localparam int ACC_REF_LSB = 2;
  // Reset values
  localparam logic [7:0] ACC_CTRL_RST = 8'h14;
  localparam logic [1:0] ACC_MASK_RST = 2'h0;
  localparam logic ACC_PWR_DOWN_RST = 1'h0;
  // Reference level: highest legal code and step in millivolts
  localparam logic [3:0] ACC_REF_MAX = 4'h9;
  localparam int ACC_REF_STEP_MV = 200;
  // Status bits
  localparam int ACC_ST_RISE = 0;
  localparam int ACC_ST_FALL = 1;
  // Wishbone answer states
  typedef enum logic {ACC_IDLE, ACC_ACK} acc_bus_t;
endpackage : acc_pkg

// file: src/acc_edge_detect.sv
`timescale 1ns/1ps
// Registers the comparator level and flags its edges
module acc_edge_detect
  import acc_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Comparator level (already synchronous)
  input wire logic level_i,
  input wire logic enable_i,
  // Edge pulses
  output logic rise_o,
  output logic fall_o
);
  logic prev_r;
  logic prev_nxt;

  // Hold last level; while disabled follow input so enabling makes no edge
  always_comb
  begin
    prev_nxt = level_i;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      prev_r <= 1'h0;
    else
      prev_r <= prev_nxt;
  end

  // Edges only while the comparator is powered
  assign rise_o = enable_i & level_i & ~prev_r;
  assign fall_o = enable_i & ~level_i & prev_r;
endmodule : acc_edge_detect

// file: sim/acc_ctrl_chk.sv
`timescale 1ns/1ps
// Watches the control block's ports
module acc_ctrl_chk
  import acc_pkg::*;
(
  // Bus and clock
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_we_i,
  input wire logic [9:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  // Comparator side
  input wire logic cmp_out_i,
  input wire logic positive_input_select_o,
  input wire logic negative_input_select_o,
  input wire logic ref_enable_o,
  input wire logic [3:0] reference_level_o,
  input wire logic cmp_power_down_o,
  input wire logic cmp_irq_src_o,
  input wire logic cmp_pin_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // Control write visible in its ack cycle
  logic wr_c;
  assign wr_c = wb_ack_o & wb_we_i & wb_sel_i[0] & (wb_adr_i == ACC_CTRL_ADDR);
  pos_sel_a: assert property (wr_c |-> positive_input_select_o == wb_dat_i[7])
    else $error("positive select not written");
  neg_sel_a: assert property (wr_c |-> negative_input_select_o == wb_dat_i[6])
    else $error("negative select not written");
  ref_en_a: assert property (ref_enable_o == (negative_input_select_o && !cmp_power_down_o))
    else $error("reference enable wrong");
  ref_lvl_a: assert property (wr_c |->
    reference_level_o == ((wb_dat_i[5:2] > 4'h9) ? 4'h9 : wb_dat_i[5:2]))
    else $error("reference level wrong");
  cmp_route_a: assert property (!cmp_power_down_o && !$past(rst_i) |->
    cmp_pin_o == $past(cmp_out_i) && cmp_irq_src_o == cmp_pin_o)
    else $error("result routing wrong");
  pwr_down_a: assert property (cmp_power_down_o |->
    !cmp_irq_src_o && !cmp_pin_o && !ref_enable_o)
    else $error("powered down outputs active");
  rsv_read_a: assert property (wb_ack_o && !wb_we_i && wb_adr_i == ACC_CTRL_ADDR |->
    wb_dat_o[1:0] == 2'h0)
    else $error("reserved bits read nonzero");
endmodule : acc_ctrl_chk

// file: sim/tb_acc_comparator_control.sv
`timescale 1ns/1ps
module tb_acc_comparator_control;
  import acc_pkg::*;
  logic clk_i = 0, rst_i = 1, cyc = 0, we = 0, cmp = 0, e;
  logic [9:0] adr = 0;
  logic [31:0] dat = 0, q, wb_dat_o;
  logic wb_ack_o, wb_err_o, psel, nsel, ren, pd, src, pin, irq;
  logic [3:0] lvl;
  logic [3:0] sel = 4'hF;
  int err_total = 0, checks_done = 0, m = 32'h14, d, sm = 0;
  acc_comparator_control i_acc_comparator_control (.clk_i(clk_i), .rst_i(rst_i),
    .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
    .wb_dat_i(dat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o),
    .cmp_out_i(cmp), .positive_input_select_o(psel), .negative_input_select_o(nsel),
    .ref_enable_o(ren), .reference_level_o(lvl), .cmp_power_down_o(pd),
    .cmp_irq_src_o(src), .cmp_pin_o(pin), .irq_o(irq));
  // 125 MHz clock
  initial forever #4 clk_i = ~clk_i;
  // Classic cycle, called right after a rising edge; held until ack or err at a rising edge
  task xfer(input logic w, input logic [9:0] a, input logic [31:0] v);
    cyc <= 1'h1;
    we <= w;
    adr <= a;
    dat <= v;
    @(posedge clk_i);
    while (wb_ack_o !== 1'h1 && wb_err_o !== 1'h1) @(posedge clk_i);
    q = wb_dat_o;
    e = wb_err_o;
    cyc <= 1'h0;
    @(posedge clk_i);
  endtask : xfer
  task chk(input string s, input logic [31:0] x, input logic [31:0] g);
    checks_done++;
    if (g !== x)
    begin
      err_total++;
      $display("unexpected %s exp %h got %h", s, x, g);
    end
  endtask : chk
  task end_sim;
    $display("checks %0d errors %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : end_sim
  // Hang guard, far beyond the expected run
  initial
  begin
    repeat (5000) @(posedge clk_i);
    err_total++;
    end_sim();
  end
  initial
  begin
    d = $urandom(42011);
    repeat (12) @(posedge clk_i);
    rst_i <= 0;
    xfer(0, ACC_CTRL_ADDR, 0);
    chk("ctrl", m, q);
    // Random control bytes, first one all ones
    for (int i = 0; i < 8; i++)
    begin
      d = (i == 0) ? 32'hFF : $urandom;
      xfer(1, ACC_CTRL_ADDR, d);
      m = d & 32'hFC;
      xfer(0, ACC_CTRL_ADDR, 0);
      chk("ctrl", m, q);
      chk("psel", m[7], psel);
      chk("nsel", m[6], nsel);
      chk("lvl", (m[5:2] > 9) ? 4'h9 : m[5:2], lvl);
    end
    // Write with byte lane 0 disabled leaves the control byte alone
    sel <= 4'hE;
    xfer(1'h1, ACC_CTRL_ADDR, 32'hFF);
    sel <= 4'hF;
    xfer(1'h0, ACC_CTRL_ADDR, 32'h0);
    chk("ctrl", m, q);
    // Unmasked rise raises irq, status read clears it
    xfer(1'h1, ACC_MASK_ADDR, 32'h3);
    cmp <= 1'h1;
    sm = sm | 1;
    repeat (3) @(posedge clk_i);
    chk("irq", 1, irq);
    chk("pin", 1, pin);
    xfer(1'h0, ACC_STAT_ADDR, 32'h0);
    chk("stat", sm, q);
    sm = 0;
    repeat (2) @(posedge clk_i);
    chk("irq", 0, irq);
    // Safe reconfiguration: mask, change, settle, clear pending, unmask
    xfer(1'h1, ACC_MASK_ADDR, 32'h0);
    cmp <= 1'h0;
    sm = sm | 2;
    repeat (3) @(posedge clk_i);
    chk("irq", 0, irq);
    xfer(1'h1, ACC_CTRL_ADDR, 32'h40);
    m = 32'h40;
    xfer(1'h0, ACC_STAT_ADDR, 32'h0);
    chk("stat", sm, q);
    sm = 0;
    xfer(1'h1, ACC_MASK_ADDR, 32'h3);
    chk("irq", 0, irq);
    chk("ren", 1, ren);
    // Power down silences result, reference and events
    xfer(1'h1, ACC_PWR_ADDR, 32'h1);
    cmp <= 1'h1;
    repeat (3) @(posedge clk_i);
    chk("pd", 1, pd);
    chk("src", 0, src);
    chk("pin", 0, pin);
    chk("ren", 0, ren);
    chk("irq", 0, irq);
    xfer(1'h0, ACC_STAT_ADDR, 32'h0);
    chk("stat", sm, q);
    xfer(1'h0, 10'h100, 32'h0);
    chk("err", 1, e);
    end_sim();
  end
endmodule : tb_acc_comparator_control
bind acc_comparator_control acc_ctrl_chk i_acc_ctrl_chk (.clk_i(clk_i), .rst_i(rst_i),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .cmp_out_i(cmp_out_i),
  .positive_input_select_o(positive_input_select_o),
  .negative_input_select_o(negative_input_select_o), .ref_enable_o(ref_enable_o),
  .reference_level_o(reference_level_o), .cmp_power_down_o(cmp_power_down_o),
  .cmp_irq_src_o(cmp_irq_src_o), .cmp_pin_o(cmp_pin_o));
